/* logic/uspl_consts.svh */
// Offsets, field positions and reset values of the upstream split control
`ifndef USPL_CONSTS_SVH
`define USPL_CONSTS_SVH

`define USPL_ADDR_W        8
`define USPL_CTRL_OFS      8'h60
`define USPL_STAT_OFS      8'hF0
`define USPL_CAP_LSB       0
`define USPL_CAP_MSB       15
`define USPL_LIM_LSB       16
`define USPL_LIM_MSB       31
`define USPL_CAPACITY      16'h0010
`define USPL_LIM_OFF       16'hFFFF
`define USPL_ST_CNT_MSB    15
`define USPL_ST_OFF_BIT    16
`define USPL_ST_STALE_BIT  17
`define USPL_ZERO32        32'h0000_0000

`endif

/* logic/uspl_pkg.sv */
// Types and shared arithmetic for the upstream split commitment control
package uspl_pkg;

	typedef logic [15:0] uspl_adq_t;
	typedef logic [31:0] uspl_word_t;

	// Saturating add then subtract, so a stale count never wraps
	function automatic uspl_adq_t uspl_step(
		input uspl_adq_t cur,
		input uspl_adq_t add,
		input uspl_adq_t sub
	);
		logic [16:0] sum;
		sum = {1'b0, cur} + {1'b0, add};
		if (sum[16])
			sum = 17'h1_FFFF;
		if (sum < {1'b0, sub})
			return 16'h0000;
		sum = sum - {1'b0, sub};
		if (sum[16])
			return 16'hFFFF;
		return sum[15:0];
	endfunction

endpackage

/* logic/uspl_acct.sv */
// Outstanding upstream commitment counter
module uspl_acct (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            track,
	input  wire uspl_pkg::uspl_adq_t add,
	input  wire uspl_pkg::uspl_adq_t sub,
	output uspl_pkg::uspl_adq_t  count
);

	uspl_pkg::uspl_adq_t count_r;
	uspl_pkg::uspl_adq_t count_nxt;

	always_comb begin
		count_nxt = count_r;
		// Frozen while untracked; completions then land on a stale figure
		if (track) begin
			count_nxt = uspl_pkg::uspl_step(count_r, add, sub);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_r <= 16'h0000;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count = count_r;

endmodule // uspl_acct

/* logic/uspl_ctrl.sv */
// Upstream split transaction commitment control register and gate
//
// Design decisions made here: the strobed register port and the register offsets.
`include "uspl_consts.svh"
module uspl_ctrl (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [`USPL_ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [31:0]                   reg_rdata,
	input  wire logic                     eeprom_load,
	input  wire uspl_pkg::uspl_adq_t      eeprom_limit,
	input  wire logic                     req_valid,
	input  wire uspl_pkg::uspl_adq_t      req_adq,
	output logic                          req_ready,
	input  wire logic                     cpl_valid,
	input  wire uspl_pkg::uspl_adq_t      cpl_adq,
	output uspl_pkg::uspl_adq_t           outstanding
);

	uspl_pkg::uspl_adq_t  limit_r;
	uspl_pkg::uspl_adq_t  limit_nxt;
	logic                 stale_r;
	logic                 stale_nxt;
	uspl_pkg::uspl_word_t rdata_r;
	uspl_pkg::uspl_word_t rdata_nxt;
	logic                 track_off;
	logic                 req_fire;
	logic                 fits;
	logic                 hit_ctrl;
	logic                 hit_stat;
	uspl_pkg::uspl_adq_t  acct_add;
	uspl_pkg::uspl_adq_t  acct_sub;

	// True when a new commitment stays within the limit
	function automatic logic uspl_fits(
		input uspl_pkg::uspl_adq_t cur,
		input uspl_pkg::uspl_adq_t add,
		input uspl_pkg::uspl_adq_t lim
	);
		logic [16:0] sum;
		sum = {1'b0, cur} + {1'b0, add};
		return sum <= {1'b0, lim};
	endfunction

	assign hit_ctrl  = (reg_addr == `USPL_CTRL_OFS);
	assign hit_stat  = (reg_addr == `USPL_STAT_OFS);
	assign track_off = (limit_r == `USPL_LIM_OFF);

	// Gate on the registered limit: a write lands next cycle
	assign fits      = uspl_fits(outstanding, req_adq, limit_r);
	assign req_ready = track_off | fits;
	assign req_fire  = req_valid & req_ready;

	// No accounting while the limit is all ones
	assign acct_add  = (req_fire && !track_off) ? req_adq : 16'h0000;
	assign acct_sub  = (cpl_valid && !track_off) ? cpl_adq : 16'h0000;

	uspl_acct u_acct (
		.clk   (clk),
		.rst   (rst),
		.track (!track_off),
		.add   (acct_add),
		.sub   (acct_sub),
		.count (outstanding)
	);

	// Limit register
	always_comb begin
		limit_nxt = limit_r;
		// Bus write beats a same-cycle EEPROM preload
		if (reg_wr && hit_ctrl) begin
			limit_nxt = reg_wdata[`USPL_LIM_MSB:`USPL_LIM_LSB];
		end else if (eeprom_load) begin
			limit_nxt = eeprom_limit;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			limit_r <= `USPL_CAPACITY;
		end else begin
			limit_r <= limit_nxt;
		end
	end

	// Stale-accounting flag
	always_comb begin
		stale_nxt = stale_r;
		if (reg_wr && hit_stat && reg_wdata[`USPL_ST_STALE_BIT]) begin
			stale_nxt = 1'b0;
		end
		// Set wins over the clear in the same cycle
		if (track_off && limit_nxt != `USPL_LIM_OFF) begin
			stale_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stale_r <= 1'b0;
		end else begin
			stale_r <= stale_nxt;
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_comb begin
		rdata_nxt = `USPL_ZERO32;
		if (reg_rd && hit_ctrl) begin
			rdata_nxt[`USPL_CAP_MSB:`USPL_CAP_LSB] = `USPL_CAPACITY;
			rdata_nxt[`USPL_LIM_MSB:`USPL_LIM_LSB] = limit_r;
		end else if (reg_rd && hit_stat) begin
			rdata_nxt[`USPL_ST_CNT_MSB:0]    = outstanding;
			rdata_nxt[`USPL_ST_OFF_BIT]      = track_off;
			rdata_nxt[`USPL_ST_STALE_BIT]    = stale_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= `USPL_ZERO32;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	AST_CAP_RO: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && hit_ctrl) |=> (reg_rdata[15:0] == 16'h0010)
	) else $error("capacity field not read as constant");

	AST_LIM_RD: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && hit_ctrl && !reg_wr) |=> (reg_rdata[31:16] == $past(limit_r))
	) else $error("limit field read mismatch");

	AST_LIM_WR: assert property (
		@(posedge clk) disable iff (rst)
		(reg_wr && hit_ctrl) |=> (limit_r == $past(reg_wdata[31:16]))
	) else $error("written limit not taken");

	AST_RST_LIM: assert property (
		@(posedge clk)
		($past(rst) && !rst) |-> (limit_r == 16'h0010)
	) else $error("limit not equal capacity after reset");

	AST_OFF_GRANT: assert property (
		@(posedge clk) disable iff (rst)
		(req_valid && limit_r == 16'hFFFF) |-> req_ready
	) else $error("request held while tracking is off");

	AST_OFF_FROZEN: assert property (
		@(posedge clk) disable iff (rst)
		(limit_r == 16'hFFFF) |=> $stable(outstanding)
	) else $error("count moved while tracking is off");

	AST_HOLD: assert property (
		@(posedge clk) disable iff (rst)
		(req_valid && limit_r != 16'hFFFF
			&& ({1'b0, outstanding} + {1'b0, req_adq}) > {1'b0, limit_r})
		|-> !req_ready
	) else $error("request over the limit was forwarded");

	AST_COUNT_UP: assert property (
		@(posedge clk) disable iff (rst)
		(req_valid && req_ready && !cpl_valid && limit_r != 16'hFFFF)
		|=> (outstanding == $past(outstanding) + $past(req_adq))
	) else $error("forwarded ADQs not added to the count");

	AST_STALE: assert property (
		@(posedge clk) disable iff (rst)
		(limit_r == 16'hFFFF && reg_wr && hit_ctrl && reg_wdata[31:16] != 16'hFFFF)
		|=> ##[0:2] stale_r
	) else $error("stale flag not raised on leaving all ones");

	// Read port, status word, reset values and accounting
	AST_RD_ZERO: assert property (
		@(posedge clk) disable iff (rst)
		!reg_rd |=> (reg_rdata == `USPL_ZERO32)
	) else $error("read data not zero outside its cycle");

	AST_UNMAPPED: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && !hit_ctrl && !hit_stat) |=> (reg_rdata == `USPL_ZERO32)
	) else $error("unmapped address read non-zero");

	AST_STAT_CNT: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && hit_stat) |=> (reg_rdata[15:0] == $past(outstanding))
	) else $error("status count mismatch");

	AST_STAT_OFF: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && hit_stat) |=> (reg_rdata[16] == $past(track_off))
	) else $error("status tracking-off bit mismatch");

	AST_STAT_STALE: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && hit_stat) |=> (reg_rdata[17] == $past(stale_r))
	) else $error("status stale bit mismatch");

	AST_STAT_HI: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && hit_stat) |=> (reg_rdata[31:18] == 14'h0000)
	) else $error("status upper bits not zero");

	AST_EE_LOAD: assert property (
		@(posedge clk) disable iff (rst)
		(eeprom_load && !(reg_wr && hit_ctrl)) |=> (limit_r == $past(eeprom_limit))
	) else $error("preload value not taken");

	AST_IDLE_LIM: assert property (
		@(posedge clk) disable iff (rst)
		(!(reg_wr && hit_ctrl) && !eeprom_load) |=> $stable(limit_r)
	) else $error("limit moved without a write");

	AST_RST_CNT: assert property (
		@(posedge clk)
		($past(rst) && !rst) |-> (outstanding == 16'h0000)
	) else $error("count not zero after reset");

	AST_RST_STALE: assert property (
		@(posedge clk)
		($past(rst) && !rst) |-> !stale_r
	) else $error("stale flag set after reset");

	AST_RST_RDATA: assert property (
		@(posedge clk)
		($past(rst) && !rst) |-> (reg_rdata == `USPL_ZERO32)
	) else $error("read data not zero after reset");

	AST_GRANT_FIT: assert property (
		@(posedge clk) disable iff (rst)
		(req_valid && ({1'b0, outstanding} + {1'b0, req_adq}) <= {1'b0, limit_r})
		|-> req_ready
	) else $error("fitting request was held");

	AST_COUNT_DOWN: assert property (
		@(posedge clk) disable iff (rst)
		(!req_fire && cpl_valid && !track_off && cpl_adq <= outstanding)
		|=> (outstanding == $past(outstanding) - $past(cpl_adq))
	) else $error("completed ADQs not subtracted");

	AST_SAT_FLOOR: assert property (
		@(posedge clk) disable iff (rst)
		(!req_fire && cpl_valid && !track_off && cpl_adq > outstanding)
		|=> (outstanding == 16'h0000)
	) else $error("count wrapped below zero");

	AST_STALE_CLR: assert property (
		@(posedge clk) disable iff (rst)
		(reg_wr && hit_stat && reg_wdata[17] && !track_off)
		|=> !stale_r
	) else $error("stale flag not cleared by write");

	AST_STALE_KEEP: assert property (
		@(posedge clk) disable iff (rst)
		(stale_r && !(reg_wr && hit_stat)) |=> stale_r
	) else $error("stale flag dropped without a clear");

	AST_STALE_HOLD: assert property (
		@(posedge clk) disable iff (rst)
		(!track_off && !(reg_wr && hit_stat)) |=> (stale_r == $past(stale_r))
	) else $error("stale flag moved while tracking");

	AST_EE_STALE: assert property (
		@(posedge clk) disable iff (rst)
		(track_off && eeprom_load && !reg_wr && eeprom_limit != `USPL_LIM_OFF) |=> stale_r
	) else $error("stale flag not raised on preload");

	AST_ACCT_IDLE: assert property (
		@(posedge clk) disable iff (rst)
		!req_fire |-> (acct_add == 16'h0000)
	) else $error("count added without a forwarded request");

	AST_ACCT_OFF: assert property (
		@(posedge clk) disable iff (rst)
		track_off |-> (acct_add == 16'h0000 && acct_sub == 16'h0000)
	) else $error("accounting active while tracking is off");

	AST_FREEZE_CPL: assert property (
		@(posedge clk) disable iff (rst)
		(track_off && cpl_valid) |=> (outstanding == $past(outstanding))
	) else $error("completion counted while tracking is off");

	AST_OFF_KEEP: assert property (
		@(posedge clk) disable iff (rst)
		(track_off && !eeprom_load && !(reg_wr && hit_ctrl)) |=> track_off
	) else $error("tracking resumed without a limit change");

endmodule // uspl_ctrl

/* dv/uspl_far.sv */
// Far-side requester and completer model
module uspl_far (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                go,
	input  wire logic                ret,
	input  wire uspl_pkg::uspl_adq_t adq,
	input  wire uspl_pkg::uspl_adq_t ret_adq,
	input  wire logic                req_ready,
	output logic                     req_valid,
	output uspl_pkg::uspl_adq_t      req_adq,
	output logic                     cpl_valid,
	output uspl_pkg::uspl_adq_t      cpl_adq
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk) begin
		cpl_valid <= ret;
		// Idle size lines toggle so stale values never look valid
		if (rst)
			cpl_adq <= 16'h0000;
		else
			cpl_adq <= ret ? ret_adq : ~cpl_adq;
		if (rst) begin
			req_valid <= 1'b0;
			req_adq   <= 16'h0000;
		end else if (req_valid && req_ready)
			req_valid <= 1'b0;
		else if (go) begin
			req_valid <= 1'b1;
			req_adq   <= adq;
		end else if (!req_valid)
			req_adq <= ~req_adq;
	end
endmodule // uspl_far

/* dv/upstream_split_commitment_ctrl_tb.sv */
// Self-checking bench for the upstream split commitment control
`include "uspl_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module upstream_split_commitment_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ld = 0, go = 0, ret = 0;
	logic [7:0]          reg_addr = 8'h00;
	logic [31:0]         reg_wdata = 32'h0000_0000, reg_rdata, d, r = 32'h081e_10a4;
	uspl_pkg::uspl_adq_t ld_v = 16'h0000, adq = 16'h0000, ret_adq = 16'h0000;
	uspl_pkg::uspl_adq_t req_adq, cpl_adq, outstanding, o = 16'h0000, lim = 16'h0010;
	logic                req_valid, req_ready, cpl_valid;
	int                  errors = 0, n_checks = 0;
	always #2 clk = ~clk;
	uspl_far far_u (.clk(clk), .rst(rst), .go(go), .ret(ret), .adq(adq), .ret_adq(ret_adq),
		.req_ready(req_ready), .req_valid(req_valid), .req_adq(req_adq),
		.cpl_valid(cpl_valid), .cpl_adq(cpl_adq));
	uspl_ctrl dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eeprom_load(ld),
		.eeprom_limit(ld_v), .req_valid(req_valid), .req_adq(req_adq),
		.req_ready(req_ready), .cpl_valid(cpl_valid), .cpl_adq(cpl_adq),
		.outstanding(outstanding));
	function automatic logic [31:0] rnd();
		r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
		return r;
	endfunction
	function automatic logic rdy_exp(input uspl_pkg::uspl_adq_t a);
		return lim == `USPL_LIM_OFF || {1'b0, o} + a <= {1'b0, lim};
	endfunction
	task automatic close_out();
		$display("errors=%0d checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= v; end
		@(posedge clk) reg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk) begin reg_rd <= 1; reg_addr <= a; end
		@(posedge clk) reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task automatic req(input uspl_pkg::uspl_adq_t a);
		int i;
		@(posedge clk) begin go <= 1; adq <= a; end
		@(posedge clk) go <= 0;
		#1 `CHK(req_ready, rdy_exp(a))
		if (!req_ready) begin
			// Drain everything so the held request can pass
			@(posedge clk) begin ret <= 1; ret_adq <= o; end
			o = 16'h0000;
			@(posedge clk) ret <= 0;
		end
		for (i = 0; i < 8 && req_valid; i++) @(posedge clk) #1;
		if (req_valid) begin errors++; close_out(); end
		if (lim != `USPL_LIM_OFF) o = o + a;
		`CHK(outstanding, o)
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		rd(`USPL_CTRL_OFS);
		`CHK(d, 32'h0010_0010)
		rd(8'h44);
		`CHK(d, `USPL_ZERO32)
		repeat (4) begin
			lim = 16'h0010 + 16'(rnd() & 32'h0000_001F);
			d = rnd();
			wr(`USPL_CTRL_OFS, {lim, d[15:0]});
			rd(`USPL_CTRL_OFS);
			`CHK(d, {lim, `USPL_CAPACITY})
			repeat (5) begin d = rnd(); req(d[3:0] + 16'h0001); end
			req(lim - o);
			req(16'h0001);
		end
		lim = `USPL_LIM_OFF;
		wr(`USPL_CTRL_OFS, {lim, 16'h0000});
		rd(`USPL_STAT_OFS);
		`CHK(d[16], 1'b1)
		req(16'h0100);
		lim = 16'h0020;
		wr(`USPL_CTRL_OFS, {lim, 16'h0000});
		rd(`USPL_STAT_OFS);
		`CHK(d[17:16], 2'b10)
		wr(`USPL_STAT_OFS, 32'h0002_0000);
		rd(`USPL_STAT_OFS);
		`CHK(d[17], 1'b0)
		req(16'h0001);
		@(posedge clk) begin ld <= 1; ld_v <= 16'h0030; end
		@(posedge clk) ld <= 0;
		rd(`USPL_CTRL_OFS);
		`CHK(d, 32'h0030_0010)
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		rd(`USPL_CTRL_OFS);
		`CHK(d, 32'h0010_0010)
		`CHK(outstanding, 16'h0000)
		close_out();
	end
endmodule // upstream_split_commitment_ctrl_tb
